// ==== design/sys_instr_pkg.sv ====
package sys_instr_pkg;
  // Model-specific register numbers
  localparam logic [31:0] MSR_KERNEL_G_BASE = 32'hC000_0102;
  localparam logic [31:0] MSR_TS_AUX = 32'hC000_0103;
  localparam logic [31:0] MSR_F_BASE = 32'h0000_1000;
  localparam logic [31:0] MSR_G_BASE = 32'h0000_1001;
  localparam logic [31:0] MSR_TS_COUNT = 32'h0000_1010;
  // Control register zero fields
  localparam int TASK_SWITCHED_FLAG_BIT = 3;
  localparam int MSW_LOAD_W = 4;
  localparam int MSW_W = 16;
  localparam logic [63:0] CR0_RESET = 64'h0000_0000_0000_0000;
  // Control register four fields
  localparam int VIRTUAL_8086_EXT_ENABLE_BIT = 0;
  localparam int CR4_FSGS_BIT = 16;
  // Segment register numbering
  localparam logic [2:0] SEG_CODE = 3'h1;
  localparam logic [2:0] SEG_F = 3'h4;
  localparam logic [2:0] SEG_G = 3'h5;
  localparam logic [2:0] SEG_COUNT = 3'h6;
  // Selector and descriptor layout, counter count and time-stamp step
  localparam int SEL_IDX_LSB = 3;
  localparam int DESC_BASE_LSB = 32;
  localparam int DESC_LIMIT_LSB = 12;
  localparam int DESC_ATTR_W = 12;
  localparam int PMC_COUNT = 4;
  localparam logic [63:0] TSC_STEP = 64'h0000_0000_0000_0001;
  // Arbitrary value, not tied to any real part
  localparam logic [63:0] FEATURE_WORD = 64'h0000_0001_0000_0000;

  typedef enum logic [4:0] {
    OP_SWAP_G, OP_CR_RD, OP_CR_WR, OP_DR_RD, OP_DR_WR, OP_MSW_LOAD, OP_MSW_STORE,
    OP_CLEAR_TS, OP_INT_DIS, OP_INT_EN, OP_MSR_RD, OP_MSR_WR, OP_PMC_RD, OP_TSC_RD,
    OP_TSCP_RD, OP_FEATURE, OP_SEG_LOAD, OP_SEG_STORE, OP_FAR_CS, OP_F_BASE_RD,
    OP_G_BASE_RD, OP_F_BASE_WR, OP_G_BASE_WR, OP_GT_LOAD, OP_IT_LOAD, OP_GT_STORE,
    OP_IT_STORE, OP_LT_LOAD, OP_TR_LOAD, OP_LT_STORE, OP_TR_STORE
  } op_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_FETCH = 2'b10
  } state_type;

  typedef struct packed {
    op_type op;
    logic [2:0] idx;
    logic [31:0] addr;
    logic [63:0] data;
    logic [15:0] lim;
  } instr_type;

  typedef struct packed {
    logic [15:0] sel;
    logic [63:0] base;
    logic [19:0] limit;
    logic [11:0] attr;
  } seg_type;

  typedef struct packed {
    logic [63:0] base;
    logic [15:0] lim;
  } table_reg_type;

  typedef struct packed {
    logic [63:0] value;
    logic [31:0] aux;
    logic [15:0] lim;
  } result_type;
endpackage

// ==== design/desc_table_mem.sv ====
`timescale 1ns/1ns
`default_nettype none
module desc_table_mem #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 64,
  parameter int IDX_W = 6
) (
  input wire logic clk, // Core clock
  input wire logic wr_en, // Write strobe
  input wire logic [IDX_W-1:0] wr_idx, // Write entry
  input wire logic [WIDTH-1:0] wr_data, // Write entry value
  input wire logic [IDX_W-1:0] rd_idx, // Read entry
  output logic [WIDTH-1:0] rd_data // Entry, one cycle after address
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Registered read keeps the fill path off the table's address decode
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_data <= mem[rd_idx];
  end
endmodule
`default_nettype wire

// ==== design/system_instruction_unit.sv ====
`timescale 1ns/1ns
`default_nettype none
module system_instruction_unit #(
  parameter int TABLE_DEPTH = 64,
  parameter int TABLE_IDX_W = 6
) (
  input wire logic clk, // Core clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire sys_instr_pkg::instr_type instr, // Decoded instruction
  input wire logic instr_valid, // Instruction offered
  input wire logic privileged, // Current level is most privileged
  input wire logic long_mode, // 64-bit mode active
  input wire logic task_switch, // Task switch event pulse
  input wire logic intr_req, // Maskable interrupt request
  input wire logic tbl_wr_en, // Descriptor table write
  input wire logic [TABLE_IDX_W-1:0] tbl_wr_idx, // Descriptor table entry
  input wire logic [63:0] tbl_wr_data, // Descriptor value
  input wire logic [63:0] pmc_in [sys_instr_pkg::PMC_COUNT], // Performance counters
  output logic ready, // Unit can take an instruction
  output logic done, // Instruction retired, one cycle
  output logic general_protection_fault, // Instruction faulted, one cycle
  output sys_instr_pkg::result_type result, // Returned value
  output logic interrupt_enable_flag, // Maskable interrupts allowed
  output logic virtual_interrupt_flag, // Virtual interrupt flag
  output logic intr_accept, // Maskable interrupt taken
  output logic task_switched_flag, // Task-switched flag copy
  output logic [15:0] status_word // Low status bits of control zero
);
  import sys_instr_pkg::*;

  state_type state;
  logic [63:0] cr [8];
  logic [63:0] dr [8];
  logic [63:0] kernel_segment_base_swap_value;
  logic [63:0] timestamp_auxiliary_value;
  logic [63:0] tsc;
  seg_type seg [6];
  seg_type local_table, task_reg;
  table_reg_type global_table, interrupt_table;
  logic [63:0] desc;
  logic gp, go, exec, fetch_req;
  op_type pend_op;
  logic [2:0] pend_idx;
  logic [15:0] pend_sel;
  logic [TABLE_IDX_W-1:0] rd_idx;

  function automatic logic msr_hit(input logic [31:0] a);
    return a == MSR_KERNEL_G_BASE || a == MSR_TS_AUX || a == MSR_F_BASE ||
      a == MSR_G_BASE || a == MSR_TS_COUNT;
  endfunction

  function automatic logic msr_base(input logic [31:0] a);
    return a == MSR_F_BASE || a == MSR_G_BASE;
  endfunction

  // Privilege and operand checks
  always_comb begin
    gp = 1'b0;
    case (instr.op)
      OP_CR_RD, OP_CR_WR: gp = !privileged;
      OP_DR_RD, OP_DR_WR: gp = !privileged;
      OP_MSW_LOAD: gp = !privileged;
      OP_CLEAR_TS: gp = !privileged;
      OP_INT_DIS, OP_INT_EN: gp = !privileged && !cr[4][VIRTUAL_8086_EXT_ENABLE_BIT];
      OP_MSR_RD, OP_MSR_WR: begin
        gp = !privileged || !msr_hit(instr.addr) ||
          (msr_base(instr.addr) && !long_mode);
      end
      OP_SEG_LOAD: gp = instr.idx == SEG_CODE || instr.idx >= SEG_COUNT;
      OP_SEG_STORE: gp = instr.idx >= SEG_COUNT;
      OP_F_BASE_RD, OP_G_BASE_RD, OP_F_BASE_WR, OP_G_BASE_WR: begin
        gp = !long_mode || !cr[4][CR4_FSGS_BIT];
      end
      default: gp = 1'b0;
    endcase
  end

  // Instruction effects below are gated by exec, so a fault only raises the fault pulse
  assign go = instr_valid && ready && state == ST_IDLE;
  assign exec = go && !gp;
  assign fetch_req = exec && (instr.op == OP_SEG_LOAD || instr.op == OP_FAR_CS ||
    instr.op == OP_LT_LOAD || instr.op == OP_TR_LOAD);
  assign rd_idx = instr.data[SEL_IDX_LSB +: TABLE_IDX_W];

  desc_table_mem #(
    .WIDTH(64),
    .DEPTH(TABLE_DEPTH),
    .IDX_W(TABLE_IDX_W)
  ) u_table (
    .clk(clk),
    .wr_en(tbl_wr_en),
    .wr_idx(tbl_wr_idx),
    .wr_data(tbl_wr_data),
    .rd_idx(rd_idx),
    .rd_data(desc)
  );

  // Descriptor loads take one extra cycle for the table read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      ready <= 1'b0;
      pend_op <= OP_SWAP_G;
      pend_idx <= 3'h0;
      pend_sel <= 16'h0000;
    end else begin
      case (state)
        ST_IDLE: begin
          ready <= !fetch_req;
          if (fetch_req) begin
            state <= ST_FETCH;
            pend_op <= instr.op;
            pend_idx <= instr.op == OP_FAR_CS ? SEG_CODE : instr.idx;
            pend_sel <= instr.data[15:0];
          end
        end
        ST_FETCH: begin
          state <= ST_IDLE;
          ready <= 1'b1;
        end
        default: begin
          state <= ST_IDLE;
          ready <= 1'b1;
        end
      endcase
    end
  end

  // Control registers and the status word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 8; i++) begin
        cr[i] <= 64'h0000_0000_0000_0000;
      end
      cr[0] <= CR0_RESET;
    end else begin
      if (exec && instr.op == OP_CR_WR) begin
        cr[instr.idx] <= instr.data;
      end
      if (exec && instr.op == OP_MSW_LOAD) begin
        cr[0][MSW_LOAD_W-1:0] <= instr.data[MSW_LOAD_W-1:0];
      end
      if (exec && instr.op == OP_CLEAR_TS) begin
        cr[0][TASK_SWITCHED_FLAG_BIT] <= 1'b0;
      end
      // A switch in the same cycle as a clear keeps the flag set
      if (task_switch) begin
        cr[0][TASK_SWITCHED_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // Debug registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 8; i++) begin
        dr[i] <= 64'h0000_0000_0000_0000;
      end
    end else if (exec && instr.op == OP_DR_WR) begin
      dr[instr.idx] <= instr.data;
    end
  end

  // Interrupt flags; extensions on and unprivileged means the virtual flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      interrupt_enable_flag <= 1'b0;
      virtual_interrupt_flag <= 1'b0;
      intr_accept <= 1'b0;
    end else begin
      if (exec && (instr.op == OP_INT_DIS || instr.op == OP_INT_EN)) begin
        if (privileged) begin
          interrupt_enable_flag <= instr.op == OP_INT_EN;
        end else begin
          virtual_interrupt_flag <= instr.op == OP_INT_EN;
        end
      end
      intr_accept <= intr_req && interrupt_enable_flag;
    end
  end

  // Free-running time-stamp counter, writable as a model register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tsc <= 64'h0000_0000_0000_0000;
    end else if (exec && instr.op == OP_MSR_WR && instr.addr == MSR_TS_COUNT) begin
      tsc <= instr.data;
    end else begin
      tsc <= tsc + TSC_STEP;
    end
  end

  // Model registers and the f/g hidden bases
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      kernel_segment_base_swap_value <= 64'h0000_0000_0000_0000;
      timestamp_auxiliary_value <= 64'h0000_0000_0000_0000;
      for (int i = 0; i < 6; i++) begin
        seg[i] <= '0;
      end
    end else begin
      if (exec) begin
        case (instr.op)
          OP_SWAP_G: begin
            kernel_segment_base_swap_value <= seg[SEG_G].base;
            seg[SEG_G].base <= kernel_segment_base_swap_value;
          end
          OP_MSR_WR: begin
            if (instr.addr == MSR_KERNEL_G_BASE) begin
              kernel_segment_base_swap_value <= instr.data;
            end
            if (instr.addr == MSR_TS_AUX) begin
              timestamp_auxiliary_value <= instr.data;
            end
            if (instr.addr == MSR_F_BASE) begin
              seg[SEG_F].base <= instr.data;
            end
            if (instr.addr == MSR_G_BASE) begin
              seg[SEG_G].base <= instr.data;
            end
          end
          OP_F_BASE_WR: seg[SEG_F].base <= instr.data;
          OP_G_BASE_WR: seg[SEG_G].base <= instr.data;
          default: ;
        endcase
      end
      // Long mode still loads the selector but drops flat-segment descriptors
      if (state == ST_FETCH && (pend_op == OP_SEG_LOAD || pend_op == OP_FAR_CS)) begin
        seg[pend_idx].sel <= pend_sel;
        if (!long_mode || pend_idx == SEG_F || pend_idx == SEG_G ||
            pend_idx == SEG_CODE) begin
          seg[pend_idx].base <= {32'h0000_0000, desc[63:DESC_BASE_LSB]};
          seg[pend_idx].limit <= desc[DESC_BASE_LSB-1:DESC_LIMIT_LSB];
          seg[pend_idx].attr <= desc[DESC_ATTR_W-1:0];
        end
      end
    end
  end

  // Descriptor-table registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      global_table <= '0;
      interrupt_table <= '0;
      local_table <= '0;
      task_reg <= '0;
    end else begin
      if (exec && instr.op == OP_GT_LOAD) begin
        global_table <= {instr.data, instr.lim};
      end
      if (exec && instr.op == OP_IT_LOAD) begin
        interrupt_table <= {instr.data, instr.lim};
      end
      if (state == ST_FETCH && (pend_op == OP_LT_LOAD || pend_op == OP_TR_LOAD)) begin
        // Both system tables come from the one global table store
        if (pend_op == OP_LT_LOAD) begin
          local_table <= {pend_sel, 32'h0000_0000, desc[63:DESC_BASE_LSB],
            desc[DESC_BASE_LSB-1:DESC_LIMIT_LSB], desc[DESC_ATTR_W-1:0]};
        end else begin
          task_reg <= {pend_sel, 32'h0000_0000, desc[63:DESC_BASE_LSB],
            desc[DESC_BASE_LSB-1:DESC_LIMIT_LSB], desc[DESC_ATTR_W-1:0]};
        end
      end
    end
  end

  // Completion, fault and returned value
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      done <= 1'b0;
      general_protection_fault <= 1'b0;
      result <= '0;
    end else begin
      done <= (exec && !fetch_req) || state == ST_FETCH;
      general_protection_fault <= go && gp;
      if (exec) begin
        result <= '0;
        case (instr.op)
          OP_CR_RD: result.value <= cr[instr.idx];
          OP_DR_RD: result.value <= dr[instr.idx];
          OP_MSW_STORE: result.value <= {48'h0000_0000_0000, cr[0][MSW_W-1:0]};
          OP_MSR_RD: begin
            case (instr.addr)
              MSR_KERNEL_G_BASE: result.value <= kernel_segment_base_swap_value;
              MSR_TS_AUX: result.value <= timestamp_auxiliary_value;
              MSR_F_BASE: result.value <= seg[SEG_F].base;
              MSR_G_BASE: result.value <= seg[SEG_G].base;
              default: result.value <= tsc;
            endcase
          end
          OP_PMC_RD: result.value <= pmc_in[instr.idx[1:0]];
          OP_TSC_RD: result.value <= tsc;
          OP_TSCP_RD: begin
            result.value <= tsc;
            result.aux <= timestamp_auxiliary_value[31:0];
          end
          OP_FEATURE: result.value <= FEATURE_WORD;
          OP_SEG_STORE: result.value <= {48'h0000_0000_0000, seg[instr.idx].sel};
          OP_F_BASE_RD: result.value <= seg[SEG_F].base;
          OP_G_BASE_RD: result.value <= seg[SEG_G].base;
          OP_GT_STORE: result <= {global_table.base, 32'h0000_0000,
            global_table.lim};
          OP_IT_STORE: result <= {interrupt_table.base, 32'h0000_0000,
            interrupt_table.lim};
          OP_LT_STORE: result.value <= {48'h0000_0000_0000, local_table.sel};
          OP_TR_STORE: result.value <= {48'h0000_0000_0000, task_reg.sel};
          default: ;
        endcase
      end
    end
  end

  // Flag copies for the rest of the core
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      task_switched_flag <= 1'b0;
      status_word <= 16'h0000;
    end else begin
      task_switched_flag <= cr[0][TASK_SWITCHED_FLAG_BIT];
      status_word <= cr[0][MSW_W-1:0];
    end
  end
endmodule
`default_nettype wire

// ==== verification/sys_instr_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module sys_instr_chk #(
  parameter int TABLE_DEPTH = 64,
  parameter int TABLE_IDX_W = 6
) (
  input wire logic clk, // Core clock
  input wire logic sys_rst, // Sync reset
  input wire sys_instr_pkg::instr_type instr, // Offered op
  input wire logic instr_valid, // Op offered
  input wire logic privileged, // Top level
  input wire logic long_mode, // 64-bit mode
  input wire logic task_switch, // Switch event
  input wire logic intr_req, // Maskable request
  input wire logic ready, // Idle
  input wire logic done, // Retire pulse
  input wire logic general_protection_fault, // Fault pulse
  input wire sys_instr_pkg::result_type result, // Returned value
  input wire logic interrupt_enable_flag, // Interrupt flag
  input wire logic intr_accept, // Interrupt taken
  input wire logic task_switched_flag // Flag copy
);
  import sys_instr_pkg::*;
  op_type op;
  logic gpf, priv_op, slow_op, fg_op;
  // Op classes that share one check
  assign op = instr.op;
  assign gpf = general_protection_fault;
  assign priv_op = op inside {OP_CR_RD, OP_CR_WR, OP_DR_RD, OP_DR_WR, OP_MSW_LOAD, OP_CLEAR_TS};
  assign fg_op = op inside {OP_F_BASE_RD, OP_G_BASE_RD, OP_F_BASE_WR, OP_G_BASE_WR};
  assign slow_op = (op == OP_SEG_LOAD && instr.idx != SEG_CODE && instr.idx < SEG_COUNT)
    || op == OP_FAR_CS || (privileged && op inside {OP_LT_LOAD, OP_TR_LOAD});
  // One domain, so clock and disable are shared
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_take;
    instr_valid && ready;
  endsequence
  sequence s_fault;
    gpf && !done;
  endsequence
  sequence s_slow_done;
    !ready && !done ##1 done && ready;
  endsequence
  a_no_double_end: assert property (!(done && gpf))
    else $error("done and fault in one cycle");
  a_priv_refused: assert property (
    s_take ##0 (!privileged && priv_op) |=> s_fault)
    else $error("privileged op not refused");
  a_msr_refused: assert property (
    s_take ##0 (!privileged && op inside {OP_MSR_RD, OP_MSR_WR}) |=> s_fault)
    else $error("model register op not refused");
  a_status_open: assert property (
    s_take ##0 (op == OP_MSW_STORE && !privileged) |=> done && !gpf)
    else $error("status store refused");
  a_feature_open: assert property (
    s_take ##0 (op == OP_FEATURE && !privileged) |=> done && result.value == FEATURE_WORD)
    else $error("feature word wrong");
  a_intr_taken: assert property (intr_req && interrupt_enable_flag |=> intr_accept)
    else $error("interrupt not taken");
  a_intr_masked: assert property (!interrupt_enable_flag |=> !intr_accept)
    else $error("masked interrupt taken");
  a_desc_wait: assert property (s_take ##0 slow_op |=> s_slow_done)
    else $error("descriptor load timing wrong");
  a_code_refused: assert property (
    s_take ##0 (op == OP_SEG_LOAD && instr.idx == SEG_CODE) |=> s_fault)
    else $error("code segment move not refused");
  a_ts_raised: assert property (
    task_switch && !instr_valid && !$past(instr_valid) |-> ##2 task_switched_flag)
    else $error("task switch flag not set");
  a_fg_long_only: assert property (s_take ##0 (!long_mode && fg_op) |=> s_fault)
    else $error("base op outside long mode");
endmodule
`default_nettype wire

// ==== verification/tb_system_instruction_unit.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_system_instruction_unit;
  import sys_instr_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  instr_type instr = '0;
  logic instr_valid = 1'b0;
  logic privileged = 1'b0;
  logic long_mode = 1'b0;
  logic task_switch = 1'b0;
  logic intr_req = 1'b0;
  logic tbl_wr_en = 1'b0;
  logic [5:0] tbl_wr_idx = 6'h0;
  logic [63:0] tbl_wr_data = 64'h0;
  logic [63:0] pmc_in [PMC_COUNT];
  logic ready, done, gp, ief, vif, iacc, tsf;
  result_type result;
  logic [15:0] status_word;
  // Bench model of the architectural state
  logic [63:0] cr0 = 64'h0, d, e, kgb, gb, aux;
  logic [15:0] lv = 16'h0, l;
  logic [31:0] seed = 32'h8083;
  int err_count = 0;
  int samples_checked = 0;
  op_type pv_ops[8] = '{OP_CR_RD, OP_CR_WR, OP_DR_RD, OP_DR_WR, OP_MSW_LOAD, OP_CLEAR_TS,
    OP_MSR_RD, OP_MSR_WR};
  op_type ld_ops[4] = '{OP_GT_LOAD, OP_IT_LOAD, OP_LT_LOAD, OP_TR_LOAD};
  op_type st_ops[4] = '{OP_GT_STORE, OP_IT_STORE, OP_LT_STORE, OP_TR_STORE};

  always #25 clk = ~clk;

  system_instruction_unit #(.TABLE_DEPTH(64), .TABLE_IDX_W(6)) u_dut (
    .clk, .sys_rst, .instr, .instr_valid, .privileged, .long_mode, .task_switch,
    .intr_req, .tbl_wr_en, .tbl_wr_idx, .tbl_wr_data, .pmc_in, .ready, .done,
    .general_protection_fault(gp), .result, .interrupt_enable_flag(ief),
    .virtual_interrupt_flag(vif), .intr_accept(iacc), .task_switched_flag(tsf),
    .status_word);

  // Fixed-seed xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [63:0] g, input logic [63:0] x);
    samples_checked++;
    if (g !== x) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  // One instruction; waits bounded, checks retire against fault
  task automatic run(input op_type o, input logic p, input logic ex,
                     input logic [2:0] i = 3'h0, input logic [63:0] dv = 64'h0,
                     input logic [31:0] a = 32'h0);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 9) begin
      @(posedge clk);
      #1;
      n++;
    end
    instr = '{o, i, a, dv, lv};
    privileged = p;
    instr_valid = 1'b1;
    @(posedge clk);
    #1;
    instr_valid = 1'b0;
    n = 0;
    // A one-cycle op answers at the take edge, so look before waiting
    while (done !== 1'b1 && gp !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({done, gp}, {!ex, ex});
    // Extra cycle so the late status copies settle
    @(posedge clk);
    #1;
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Whole run is about 120 cycles; 2000 means a hang
  initial begin
    #100_000;
    err_count++;
    give_verdict();
  end

  initial begin
    foreach (pmc_in[k]) pmc_in[k] = {rnd(), rnd()};
    repeat (3) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    // Control zero, partial status load, user-level store
    d = {rnd(), rnd()};
    run(OP_CR_WR, 1'b1, 1'b0, 3'h0, d);
    cr0 = d;
    chk(status_word, cr0[15:0]);
    run(OP_MSW_LOAD, 1'b1, 1'b0, 3'h0, ~d);
    cr0[3:0] = ~d[3:0];
    chk({tsf, status_word}, {cr0[3], cr0[15:0]});
    run(OP_MSW_STORE, 1'b0, 1'b0);
    chk(result.value, {48'h0, cr0[15:0]});
    run(OP_CR_RD, 1'b1, 1'b0);
    chk(result.value, cr0);
    foreach (pv_ops[k]) begin
      run(pv_ops[k], 1'b0, 1'b1, 3'h0, {rnd(), rnd()}, MSR_KERNEL_G_BASE);
      chk(status_word, cr0[15:0]);
    end
    $display("control test done");
    // Task switch raises the flag, clear drops it
    task_switch = 1'b1;
    @(posedge clk);
    #1;
    task_switch = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(tsf, 1'b1);
    run(OP_CLEAR_TS, 1'b1, 1'b0);
    cr0[3] = 1'b0;
    chk({tsf, status_word}, {1'b0, cr0[15:0]});
    $display("task flag test done");
    // Interrupt flag, then the virtual flag once extensions are on
    intr_req = 1'b1;
    run(OP_INT_EN, 1'b1, 1'b0);
    chk({ief, vif, iacc}, 3'b101);
    run(OP_INT_DIS, 1'b1, 1'b0);
    chk({ief, vif, iacc}, 3'b000);
    run(OP_INT_EN, 1'b0, 1'b1);
    run(OP_CR_WR, 1'b1, 1'b0, 3'h4, 64'h1_0001);
    run(OP_INT_EN, 1'b0, 1'b0);
    chk({ief, vif, iacc}, 3'b010);
    run(OP_INT_DIS, 1'b0, 1'b0);
    chk({ief, vif}, 2'b00);
    intr_req = 1'b0;
    $display("interrupt test done");
    // Model registers, base swap and base instructions
    long_mode = 1'b1;
    kgb = {rnd(), rnd()};
    gb = {rnd(), rnd()};
    aux = {rnd(), rnd()};
    d = {rnd(), rnd()};
    run(OP_MSR_WR, 1'b1, 1'b0, 3'h0, kgb, MSR_KERNEL_G_BASE);
    run(OP_MSR_WR, 1'b1, 1'b0, 3'h0, gb, MSR_G_BASE);
    run(OP_MSR_WR, 1'b1, 1'b0, 3'h0, aux, MSR_TS_AUX);
    run(OP_SWAP_G, 1'b1, 1'b0);
    run(OP_MSR_RD, 1'b1, 1'b0, 3'h0, 64'h0, MSR_KERNEL_G_BASE);
    chk(result.value, gb);
    run(OP_G_BASE_RD, 1'b0, 1'b0);
    chk(result.value, kgb);
    run(OP_F_BASE_WR, 1'b0, 1'b0, 3'h0, d);
    run(OP_MSR_RD, 1'b1, 1'b0, 3'h0, 64'h0, MSR_F_BASE);
    chk(result.value, d);
    run(OP_MSR_RD, 1'b1, 1'b1, 3'h0, 64'h0, 32'h0);
    run(OP_TSC_RD, 1'b0, 1'b0);
    d = result.value;
    run(OP_TSCP_RD, 1'b0, 1'b0);
    // Back-to-back single-cycle takes sit two clocks apart
    chk(result.value - d, 64'h2);
    chk(result.aux, aux[31:0]);
    foreach (pmc_in[k]) begin
      run(OP_PMC_RD, 1'b0, 1'b0, 3'(k));
      chk(result.value, pmc_in[k]);
    end
    run(OP_FEATURE, 1'b0, 1'b0);
    chk(result.value, FEATURE_WORD);
    $display("model register test done");
    // Segment loads fetch entry 5 of the table
    e = {rnd(), rnd()};
    tbl_wr_idx = 6'h5;
    tbl_wr_data = e;
    tbl_wr_en = 1'b1;
    @(posedge clk);
    #1;
    tbl_wr_en = 1'b0;
    long_mode = 1'b0;
    run(OP_SEG_LOAD, 1'b0, 1'b0, SEG_G, 64'h2d);
    run(OP_G_BASE_RD, 1'b0, 1'b1);
    run(OP_MSR_RD, 1'b1, 1'b1, 3'h0, 64'h0, MSR_G_BASE);
    run(OP_SEG_LOAD, 1'b0, 1'b1, SEG_CODE, 64'h28);
    run(OP_SEG_LOAD, 1'b0, 1'b1, 3'h6, 64'h28);
    run(OP_FAR_CS, 1'b0, 1'b0, SEG_CODE, 64'h28);
    long_mode = 1'b1;
    run(OP_MSR_RD, 1'b1, 1'b0, 3'h0, 64'h0, MSR_G_BASE);
    chk(result.value, {32'h0, e[63:32]});
    run(OP_SEG_STORE, 1'b0, 1'b0, SEG_G);
    chk(result.value, 64'h2d);
    run(OP_SEG_LOAD, 1'b0, 1'b0, SEG_F, 64'h28);
    run(OP_MSR_RD, 1'b1, 1'b0, 3'h0, 64'h0, MSR_F_BASE);
    chk(result.value, {32'h0, e[63:32]});
    $display("segment test done");
    // Table registers: pseudo-descriptors, then selectors only
    foreach (ld_ops[k]) begin
      d = k < 2 ? {rnd(), rnd()} : 64'h28;
      l = k < 2 ? 16'(rnd()) : 16'h0;
      lv = l;
      run(ld_ops[k], 1'b1, 1'b0, 3'h0, d);
      run(st_ops[k], 1'b1, 1'b0);
      chk({result.value, result.lim}, {d, l});
    end
    $display("table register test done");
    give_verdict();
  end
endmodule

bind system_instruction_unit sys_instr_chk #(
  .TABLE_DEPTH(TABLE_DEPTH),
  .TABLE_IDX_W(TABLE_IDX_W)
) u_chk (.clk, .sys_rst, .instr, .instr_valid, .privileged, .long_mode, .task_switch,
  .intr_req, .ready, .done, .general_protection_fault, .result, .interrupt_enable_flag,
  .intr_accept, .task_switched_flag);
`default_nettype wire
